//--- verilog/qdr_flash_dev.sv
// flash device end: quad ddr read command sequencer
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "qdr_regs.svh"
module qdr_flash_dev #(
    parameter int ARRAY_BYTES = 256,
    parameter int AW = 8
) (
    input logic mclk,
    input logic rst_n,
    qdr_link_if.dev link,
    input logic [7:0] configuration_register,
    input logic extended_address_flag,
    input logic enhanced_table,
    input logic pattern_enable,
    input logic [7:0] learning_pattern,
    input logic mem_we,
    input logic [AW-1:0] mem_addr,
    input logic [7:0] mem_wdata,
    output logic continuous_mode,
    output logic read_active
);
    localparam logic [15:0] STD_LAT = `QDR_STD_LAT_TABLE;
    localparam logic [15:0] ENH_LAT = `QDR_ENH_LAT_TABLE;

    qdr_pkg::qdr_dev_state_type state;
    logic sck_q;
    logic cs_q;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic [7:0] mem [ARRAY_BYTES];
    logic [7:0] opcode_sr;
    logic [31:0] addr_sr;
    logic [31:0] next_addr_sr;
    logic [3:0] addr_nibs;
    logic [5:0] cnt;
    logic [3:0] mode_hi;
    logic mode_cont;
    logic mode_seen;
    logic [3:0] frame_cyc;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] next_rd_addr;
    logic [1:0] lc;
    logic [3:0] dummy_cycles;
    logic [5:0] data_slot;
    logic [5:0] launch_slot;
    logic [5:0] pat_off;
    logic op_valid;
    logic wide_addr;
    logic addr_last;

    // edge detection on the sampled serial clock; one mclk behind the pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sck_q <= link.sck;
            cs_q <= link.cs_n;
        end
    end

    assign rise = !link.cs_n && link.sck && !sck_q;
    assign fall = !link.cs_n && !link.sck && sck_q;
    assign cs_fall = !link.cs_n && cs_q;
    assign cs_rise = link.cs_n && !cs_q;

    assign lc = configuration_register[`QDR_CFG_LC_LSB +: 2];
    // part variant picks the table; the mode cycle is outside both
    assign dummy_cycles = enhanced_table ? ENH_LAT[{lc, 2'b00} +: 4]
                                         : STD_LAT[{lc, 2'b00} +: 4];
    assign data_slot = {1'b0, dummy_cycles, 1'b0};
    assign launch_slot = (state == qdr_pkg::dev_mode) ? 6'h00 : cnt + 6'h01;
    assign pat_off = launch_slot - (data_slot - `QDR_PREAMBLE_SLOTS);

    assign op_valid = configuration_register[`QDR_CFG_QUAD_BIT]
                      && (opcode_sr == `QDR_OP_READ_ED
                      || opcode_sr == `QDR_OP_READ_EE);
    assign wide_addr = (opcode_sr == `QDR_OP_READ_EE) || extended_address_flag;
    // lane 3 carries address bits here; a pause input would have no say
    assign next_addr_sr = {addr_sr[27:0], link.io_lvl};
    assign addr_last = (cnt == {2'b00, addr_nibs} - 6'h01);
    assign next_rd_addr = (rd_addr == AW'(ARRAY_BYTES - 1)) ? '0 : rd_addr + 1'b1;

    // command sequence
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= qdr_pkg::dev_idle;
            cnt <= 6'h00;
        end else if (cs_rise) begin
            state <= qdr_pkg::dev_idle;
        end else if (cs_fall) begin
            state <= continuous_mode ? qdr_pkg::dev_addr : qdr_pkg::dev_cmd;
            cnt <= 6'h00;
        end else if (rise || fall) begin
            unique case (state)
                qdr_pkg::dev_cmd: begin
                    // instruction is single rate: falls in between are ignored
                    if (rise) begin
                        cnt <= cnt + 6'h01;
                    end else if (cnt == `QDR_INSTR_BITS) begin
                        cnt <= 6'h00;
                        state <= op_valid ? qdr_pkg::dev_addr : qdr_pkg::dev_ignore;
                    end
                end
                qdr_pkg::dev_addr: begin
                    if (addr_last) begin
                        cnt <= 6'h00;
                        state <= qdr_pkg::dev_mode;
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
                qdr_pkg::dev_mode: begin
                    if (fall) begin
                        state <= qdr_pkg::dev_dummy;
                    end
                end
                qdr_pkg::dev_dummy: begin
                    if (cnt == data_slot - 6'h01) begin
                        state <= qdr_pkg::dev_data;
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
                qdr_pkg::dev_idle, qdr_pkg::dev_data, qdr_pkg::dev_ignore: begin
                    state <= state;
                end
                default: begin
                    state <= qdr_pkg::dev_idle;
                end
            endcase
        end
    end

    // shift registers for instruction, address and mode byte
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            opcode_sr <= 8'h00;
            addr_sr <= 32'h0000_0000;
            addr_nibs <= `QDR_ADDR_NIBS_3B;
            mode_hi <= 4'h0;
            mode_cont <= 1'b0;
        end else if (rise || fall) begin
            if (state == qdr_pkg::dev_cmd && rise) begin
                opcode_sr <= {opcode_sr[6:0], link.io_lvl[0]};
            end
            // width kept for continuous frames, which carry no instruction
            if (state == qdr_pkg::dev_cmd && fall && cnt == `QDR_INSTR_BITS && op_valid) begin
                addr_nibs <= wide_addr ? `QDR_ADDR_NIBS_4B : `QDR_ADDR_NIBS_3B;
            end
            if (state == qdr_pkg::dev_addr) begin
                addr_sr <= next_addr_sr;
            end
            if (state == qdr_pkg::dev_mode && rise) begin
                mode_hi <= link.io_lvl;
            end
            if (state == qdr_pkg::dev_mode && fall) begin
                mode_cont <= (mode_hi == ~link.io_lvl);
            end
        end
    end

    // continuous mode; decided only when the frame ends
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            continuous_mode <= 1'b0;
            mode_seen <= 1'b0;
            frame_cyc <= 4'h0;
        end else if (cs_fall) begin
            mode_seen <= 1'b0;
            frame_cyc <= 4'h0;
        end else if (cs_rise) begin
            if (mode_seen) begin
                continuous_mode <= mode_cont;
            end else if (frame_cyc <= `QDR_EXIT_MAX_CYCLES) begin
                continuous_mode <= 1'b0;
            end
        end else begin
            if (rise && frame_cyc != 4'hf) begin
                frame_cyc <= frame_cyc + 4'h1;
            end
            if (state == qdr_pkg::dev_mode && fall) begin
                mode_seen <= 1'b1;
            end
        end
    end

    // read address: any start byte, upper bits beyond the array mirror
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_addr <= '0;
        end else if (state == qdr_pkg::dev_addr && (rise || fall) && addr_last) begin
            rd_addr <= next_addr_sr[AW-1:0];
        end else if (state == qdr_pkg::dev_data && rise) begin
            rd_addr <= next_rd_addr;
        end
    end

    // lane drive: a value is launched on the edge before the one it belongs to
    always_ff @(posedge mclk) begin
        if (!rst_n || cs_rise) begin
            link.dev_out <= 4'h0;
            link.dev_oe <= 4'h0;
        end else if (rise || fall) begin
            if ((state == qdr_pkg::dev_mode && fall) || state == qdr_pkg::dev_dummy) begin
                if (launch_slot == data_slot) begin
                    link.dev_out <= mem[rd_addr][7:4];
                    link.dev_oe <= 4'hf;
                end else if (pattern_enable && launch_slot >= data_slot - `QDR_PREAMBLE_SLOTS) begin
                    link.dev_out <= {4{learning_pattern[3'd7 - pat_off[2:0]]}};
                    link.dev_oe <= 4'hf;
                end else begin
                    link.dev_oe <= 4'h0;
                end
            end else if (state == qdr_pkg::dev_data) begin
                link.dev_out <= rise ? mem[rd_addr][3:0] : mem[rd_addr][7:4];
                link.dev_oe <= 4'hf;
            end else begin
                link.dev_oe <= 4'h0;
            end
        end
    end

    // array contents loaded from the user side; no program path here
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    assign read_active = (state == qdr_pkg::dev_data);

endmodule // qdr_flash_dev

//--- verilog/qdr_regs.svh
// constants for the quad ddr flash read link
// What this block does
// - quad enable bit 1 must be set
// - EDh without extended flag: three address bytes
// - EDh with extended flag: four address bytes
// - EEh always takes four address bytes
// - address nibbles on both clock edges
// - mode follows address; data nibble per edge
// - serial clock at most 66 MHz
// - dummy cycles from latency code field
// - standard or enhanced table, mode cycle outside both
// - host releases lanes during dummy cycles
// - complementary mode nibbles enter continuous mode
// - other mode nibbles leave continuous mode
// - short invalid frame exits continuous mode
// - any start byte, address increments per byte
// - address wraps to zero after top
// - host keeps select low through mode, dummy
// - pause function ignored during this read
// - preamble in last four dummy cycles
// - host released lanes before preamble starts
// - learning pattern same on every lane
// - host records the learning pattern during each preamble
`ifndef QDR_REGS_SVH
`define QDR_REGS_SVH

`define QDR_OP_READ_ED 8'hed
`define QDR_OP_READ_EE 8'hee
`define QDR_CFG_QUAD_BIT 1
`define QDR_CFG_LC_LSB 3
`define QDR_STD_LAT_TABLE 16'h8765
`define QDR_ENH_LAT_TABLE 16'h7654
`define QDR_PATTERN_DEFAULT 8'h34
`define QDR_INSTR_BITS 6'h08
`define QDR_ADDR_NIBS_3B 4'h6
`define QDR_ADDR_NIBS_4B 4'h8
`define QDR_PREAMBLE_SLOTS 6'h08
`define QDR_EXIT_MAX_CYCLES 4'h8
`define QDR_INSTR_EDGES 8'h10
`define QDR_EXIT_EDGES 8'h08

`define QDR_MCLK_KHZ 100000
`define QDR_SCK_MAX_KHZ 66000
`define QDR_SCK_HALF_MIN ((`QDR_MCLK_KHZ + 2 * `QDR_SCK_MAX_KHZ - 1) / (2 * `QDR_SCK_MAX_KHZ))
`define QDR_SCK_HALF_DEFAULT 2

`define QDR_REG_CTRL 8'h00
`define QDR_REG_ADDR 8'h04
`define QDR_REG_COUNT 8'h08
`define QDR_REG_STATUS 8'h0c
`define QDR_REG_DATA 8'h10
`define QDR_REG_PATTERN 8'h14
`define QDR_CTRL_GO 0
`define QDR_CTRL_OP_EE 1
`define QDR_CTRL_EXT 2
`define QDR_CTRL_SKIP 3
`define QDR_CTRL_EXIT 4
`define QDR_CTRL_MODE_LSB 8
`define QDR_CTRL_DUMMY_LSB 16
`define QDR_STAT_BUSY 0
`define QDR_STAT_DONE 1
`define QDR_DUMMY_RESET 4'h5
`define QDR_COUNT_RESET 3'h4

`endif

//--- verilog/qdr_pkg.sv
// types shared by both ends of the quad ddr read link
package qdr_pkg;
    typedef enum logic [2:0] {
        dev_idle, dev_cmd, dev_addr, dev_mode, dev_dummy, dev_data, dev_ignore
    } qdr_dev_state_type;
    typedef enum logic [1:0] {host_idle, host_run, host_tail} qdr_host_state_type;
endpackage

//--- verilog/qdr_link_if.sv
// link wires between the flash controller and the flash device
`timescale 1ns/1ps
interface qdr_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] host_out;
    logic [3:0] host_oe;
    logic [3:0] dev_out;
    logic [3:0] dev_oe;
    logic [3:0] io_lvl;

    // pull-up on a lane nobody drives
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (host_oe[i]) begin
                io_lvl[i] = host_out[i];
            end else if (dev_oe[i]) begin
                io_lvl[i] = dev_out[i];
            end else begin
                io_lvl[i] = 1'b1;
            end
        end
    end

    modport host (output cs_n, output sck, output host_out, output host_oe, input io_lvl);
    modport dev (input cs_n, input sck, input io_lvl, output dev_out, output dev_oe);
endinterface // qdr_link_if

//--- verilog/qdr_flash_host.sv
// flash controller end: ahb-lite registers driving a quad ddr read
`timescale 1ns/1ps
`include "qdr_regs.svh"
module qdr_flash_host #(
    parameter int SCK_HALF = `QDR_SCK_HALF_DEFAULT
) (
    input logic mclk,
    input logic rst_n,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    qdr_link_if.host link
);
    // device samples one mclk late, so a half period below two cycles fails
    localparam int HALF_A = (SCK_HALF > `QDR_SCK_HALF_MIN) ? SCK_HALF : `QDR_SCK_HALF_MIN;
    localparam int HALF = (HALF_A < 2) ? 2 : HALF_A;
    localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

    qdr_pkg::qdr_host_state_type hstate;
    logic take;
    logic wr_pend;
    logic [7:0] wr_off;
    logic [31:0] rd_mux;
    logic op_ee;
    logic ext;
    logic skip;
    logic [7:0] mode;
    logic [3:0] dummy;
    logic [31:0] addr;
    logic [2:0] count;
    logic done;
    logic [31:0] data;
    logic [7:0] pattern;
    logic go;
    logic go_exit;
    logic exit_run;
    logic [7:0] div;
    logic [7:0] n;
    logic [7:0] ins;
    logic [7:0] an;
    logic [7:0] ms;
    logic [7:0] ds;
    logic [7:0] dstart;
    logic [7:0] frame_end;
    logic [7:0] nib_pos;
    logic [7:0] dk;
    logic [7:0] opcode;
    logic [3:0] d_out;
    logic [3:0] d_oe;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && hready && htrans[1];

    always_comb begin
        unique case (haddr[7:0])
            `QDR_REG_CTRL: rd_mux = {12'h000, dummy, mode, 3'b000, 1'b0, skip, ext, op_ee, 1'b0};
            `QDR_REG_ADDR: rd_mux = addr;
            `QDR_REG_COUNT: rd_mux = {29'h0, count};
            `QDR_REG_STATUS: rd_mux = {30'h0, done, hstate != qdr_pkg::host_idle};
            `QDR_REG_DATA: rd_mux = data;
            `QDR_REG_PATTERN: rd_mux = {24'h0, pattern};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in the address phase: zero wait states
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_off <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= take && hwrite;
            if (take) begin
                wr_off <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    assign go = wr_pend && wr_off == `QDR_REG_CTRL && hstate == qdr_pkg::host_idle
                && (hwdata[`QDR_CTRL_GO] || hwdata[`QDR_CTRL_EXIT]);
    assign go_exit = hwdata[`QDR_CTRL_EXIT];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op_ee <= 1'b0;
            ext <= 1'b0;
            skip <= 1'b0;
            mode <= 8'h00;
            dummy <= `QDR_DUMMY_RESET;
            addr <= 32'h0000_0000;
            count <= `QDR_COUNT_RESET;
        end else if (wr_pend && hstate == qdr_pkg::host_idle) begin
            if (wr_off == `QDR_REG_CTRL) begin
                op_ee <= hwdata[`QDR_CTRL_OP_EE];
                ext <= hwdata[`QDR_CTRL_EXT];
                skip <= hwdata[`QDR_CTRL_SKIP];
                mode <= hwdata[`QDR_CTRL_MODE_LSB +: 8];
                dummy <= hwdata[`QDR_CTRL_DUMMY_LSB +: 4];
            end
            if (wr_off == `QDR_REG_ADDR) begin
                addr <= hwdata;
            end
            if (wr_off == `QDR_REG_COUNT) begin
                count <= hwdata[2:0];
            end
        end
    end

    // frame geometry in serial clock edges, edge 0 the first rise
    assign ins = skip ? 8'h00 : `QDR_INSTR_EDGES;
    assign an = (op_ee || ext) ? 8'h08 : 8'h06;
    assign ms = ins + an;
    assign ds = ms + 8'h02;
    assign dstart = ds + {3'b000, dummy, 1'b0};
    assign frame_end = exit_run ? `QDR_EXIT_EDGES : dstart + {4'h0, count, 1'b0};
    assign nib_pos = an - 8'h01 - (n - ins);
    assign dk = n - dstart;
    assign opcode = op_ee ? `QDR_OP_READ_EE : `QDR_OP_READ_ED;

    always_comb begin
        d_out = 4'h0;
        d_oe = 4'h0;
        if (exit_run) begin
            d_out = 4'hf;
            d_oe = 4'hf;
        end else if (n < ins) begin
            d_out = {3'b000, opcode[3'd7 - n[3:1]]};
            d_oe = 4'h1;
        end else if (n < ms) begin
            d_out = addr[{nib_pos[2:0], 2'b00} +: 4];
            d_oe = 4'hf;
        end else if (n < ds) begin
            d_out = (n == ms) ? mode[7:4] : mode[3:0];
            d_oe = 4'hf;
        end
    end

    // select stays low until every byte asked for has arrived
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hstate <= qdr_pkg::host_idle;
            link.cs_n <= 1'b1;
            link.sck <= 1'b0;
            link.host_out <= 4'h0;
            link.host_oe <= 4'h0;
            n <= 8'h00;
            div <= 8'h00;
            exit_run <= 1'b0;
        end else begin
            unique case (hstate)
                qdr_pkg::host_idle: begin
                    if (go) begin
                        hstate <= qdr_pkg::host_run;
                        link.cs_n <= 1'b0;
                        n <= 8'h00;
                        div <= 8'h01;
                        exit_run <= go_exit;
                    end
                end
                qdr_pkg::host_run: begin
                    div <= (div == HALF_LAST) ? 8'h00 : div + 8'h01;
                    if (div == 8'h01) begin
                        if (n == frame_end) begin
                            link.cs_n <= 1'b1;
                            link.host_oe <= 4'h0;
                            hstate <= qdr_pkg::host_tail;
                        end else begin
                            link.host_out <= d_out;
                            link.host_oe <= d_oe;
                        end
                    end
                    if (div == 8'h00) begin
                        link.sck <= ~link.sck;
                        n <= n + 8'h01;
                    end
                end
                qdr_pkg::host_tail: begin
                    div <= (div == HALF_LAST) ? 8'h00 : div + 8'h01;
                    if (div == 8'h00) begin
                        hstate <= qdr_pkg::host_idle;
                    end
                end
                default: begin
                    hstate <= qdr_pkg::host_idle;
                end
            endcase
        end
    end

    // capture on each edge what the device launched on the edge before
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            data <= 32'h0000_0000;
            pattern <= 8'h00;
            done <= 1'b0;
        end else begin
            if (go) begin
                data <= 32'h0000_0000;
            end else if (hstate == qdr_pkg::host_run && div == 8'h00 && !exit_run) begin
                if (n >= dstart - 8'h08 && n < dstart) begin
                    pattern <= {pattern[6:0], link.io_lvl[0]};
                end else if (n >= dstart && n < frame_end) begin
                    data[{dk[2:1], ~dk[0], 2'b00} +: 4] <= link.io_lvl;
                end
            end
            if (hstate == qdr_pkg::host_run && div == 8'h01 && n == frame_end) begin
                done <= 1'b1;
            end else if (wr_pend && wr_off == `QDR_REG_STATUS && hwdata[`QDR_STAT_DONE]) begin
                done <= 1'b0;
            end
        end
    end

endmodule // qdr_flash_host

//--- testbench/qdr_link_checker.sv
// assertions on the wires between flash controller and flash device
`timescale 1ns/1ps
module qdr_link_checker (
    input logic mclk,
    input logic rst_n,
    input logic cs_n,
    input logic sck,
    input logic [3:0] host_out,
    input logic [3:0] host_oe,
    input logic [3:0] dev_out,
    input logic [3:0] dev_oe,
    input logic [3:0] io_lvl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_no_contention: assert property (!(|(host_oe & dev_oe)))
        else $error("both ends drive a lane");
    chk_dev_all_lanes: assert property (dev_oe == 4'h0 || dev_oe == 4'hf)
        else $error("device drives a partial lane set");
    chk_dev_silent_start: assert property ($fell(cs_n) |-> (dev_oe == 4'h0) [*8])
        else $error("device drives during the request");
    chk_idle_released: assert property (cs_n [*3] |-> host_oe == 4'h0 && dev_oe == 4'h0)
        else $error("lane driven while deselected");
    chk_frame_ends_low: assert property ($rose(cs_n) |-> !sck)
        else $error("frame ends with a half byte");
    chk_sck_half: assert property ($changed(sck) |=> $stable(sck))
        else $error("serial clock half period too short");
    // host lanes move mid-half so the device samples settled data
    chk_host_mid_half: assert property (!cs_n && !$past(cs_n) && $changed(host_out) |-> $stable(sck))
        else $error("host lane changed with the clock");
    chk_dev_hold: assert property (dev_oe[0] && $past(dev_oe[0]) && $changed(dev_out)
        |=> $stable(dev_out) || !dev_oe[0])
        else $error("device nibble held under a half period");
    chk_gap_min: assert property ($rose(cs_n) |=> cs_n)
        else $error("select high gap too short");
endmodule // qdr_link_checker

//--- testbench/quad_ddr_flash_read_tb_top.sv
// bench joining controller and device over the quad ddr read link
`timescale 1ns/1ps
`include "qdr_regs.svh"
module quad_ddr_flash_read_tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, mem_we = 1'b0;
    logic ext_flag = 1'b0, enh = 1'b0, pat_en = 1'b0, saw_act = 1'b0;
    logic hready, hresp, cont, rd_act;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, data_word;
    logic [7:0] cfg = 8'h02, pattern = 8'h34, mem_addr = 8'h0, mem_wdata = 8'h0;
    int err_count = 0, checks_done = 0;

    qdr_link_if link();
    qdr_flash_host #(.SCK_HALF(2)) qdr_flash_host_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link));
    qdr_flash_dev qdr_flash_dev_i (.mclk(mclk), .rst_n(rst_n), .link(link),
        .configuration_register(cfg), .extended_address_flag(ext_flag), .enhanced_table(enh),
        .pattern_enable(pat_en), .learning_pattern(pattern), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .continuous_mode(cont),
        .read_active(rd_act));
    qdr_link_checker qdr_link_checker_i (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n),
        .sck(link.sck), .host_out(link.host_out), .host_oe(link.host_oe),
        .dev_out(link.dev_out), .dev_oe(link.dev_oe), .io_lvl(link.io_lvl));

    initial begin
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rd_act === 1'b1) begin
            saw_act <= 1'b1;
        end
    end

    function automatic logic [7:0] mem_val(input logic [7:0] a);
        return a * 8'h07 + 8'h3c;
    endfunction

    // 8-bit sum wraps exactly at the 256-byte array top
    function automatic logic [31:0] exp_word(input logic [7:0] a);
        return {mem_val(a + 8'h03), mem_val(a + 8'h02), mem_val(a + 8'h01), mem_val(a)};
    endfunction

    function automatic logic [31:0] ctl(input logic [7:0] flags, input logic [7:0] mode,
        input logic [3:0] dummy);
        return {12'h0, dummy, mode, flags};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic run_frame(input logic [31:0] ctrl, input logic [31:0] a);
        int n;
        n = 0;
        ahb(1'b1, `QDR_REG_ADDR, a);
        ahb(1'b1, `QDR_REG_CTRL, ctrl);
        do begin
            ahb(1'b0, `QDR_REG_STATUS, 32'h0);
            n++;
        end while (rd[`QDR_STAT_DONE] !== 1'b1 && n < 500);
        check("frame done", {31'h0, rd[`QDR_STAT_DONE]}, 32'h1);
        ahb(1'b0, `QDR_REG_DATA, 32'h0);
        data_word = rd;
        ahb(1'b1, `QDR_REG_STATUS, 32'h2);
    endtask

    task automatic t_reset;
        ahb(1'b0, `QDR_REG_STATUS, 32'h0);
        check("status reset", rd, 32'h0);
        check("okay response", {31'h0, hresp}, 32'h0);
        ahb(1'b0, `QDR_REG_COUNT, 32'h0);
        check("count reset", rd, 32'h4);
        ahb(1'b1, 8'h40, 32'hffff_ffff);
        ahb(1'b0, 8'h40, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_addr_widths;
        run_frame(ctl(8'h01, 8'h00, 4'h5), 32'h1234_5610);
        check("ed three byte", data_word, exp_word(8'h10));
        check("data phase seen", {31'h0, saw_act}, 32'h1);
        ext_flag <= 1'b1;
        run_frame(ctl(8'h05, 8'h00, 4'h5), 32'h7654_32fe);
        check("ed four byte wrap", data_word, exp_word(8'hfe));
        ext_flag <= 1'b0;
        run_frame(ctl(8'h03, 8'h00, 4'h5), 32'h0a0b_0c83);
        check("ee four byte", data_word, exp_word(8'h83));
        ahb(1'b1, `QDR_REG_COUNT, 32'h2);
        run_frame(ctl(8'h03, 8'h00, 4'h5), 32'h0000_00a0);
        check("two bytes", data_word, exp_word(8'ha0) & 32'h0000_ffff);
        ahb(1'b1, `QDR_REG_COUNT, 32'h4);
    endtask

    task automatic t_continuous;
        run_frame(ctl(8'h01, 8'h5a, 4'h5), 32'h0000_0020);
        check("enter cont", {31'h0, cont}, 32'h1);
        run_frame(ctl(8'h09, 8'ha5, 4'h5), 32'h0000_0031);
        check("cont data", data_word, exp_word(8'h31));
        check("stay cont", {31'h0, cont}, 32'h1);
        run_frame(ctl(8'h09, 8'h55, 4'h5), 32'h0000_0042);
        check("cont last data", data_word, exp_word(8'h42));
        check("leave cont", {31'h0, cont}, 32'h0);
    endtask

    task automatic t_exit;
        // four-byte address so the short exit frame never reaches the mode byte
        run_frame(ctl(8'h03, 8'hc3, 4'h5), 32'h0000_0050);
        check("enter cont again", {31'h0, cont}, 32'h1);
        run_frame(ctl(8'h11, 8'h00, 4'h5), 32'h0);
        check("exit frame", {31'h0, cont}, 32'h0);
    endtask

    task automatic t_enhanced_pattern;
        enh <= 1'b1;
        pat_en <= 1'b1;
        cfg <= 8'h12;
        run_frame(ctl(8'h01, 8'h00, 4'h6), 32'h0000_00ff);
        check("enhanced latency", data_word, exp_word(8'hff));
        ahb(1'b0, `QDR_REG_PATTERN, 32'h0);
        check("preamble", rd, 32'h34);
    endtask

    // quad bit clear: device stays off the lanes, pull-ups give all ones
    task automatic t_no_quad;
        cfg <= 8'h10;
        run_frame(ctl(8'h01, 8'h5a, 4'h6), 32'h0000_0060);
        check("quad off data", data_word, 32'hffff_ffff);
        check("quad off cont", {31'h0, cont}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            @(posedge mclk);
            mem_we <= 1'b1;
            mem_addr <= i[7:0];
            mem_wdata <= mem_val(i[7:0]);
        end
        @(posedge mclk);
        mem_we <= 1'b0;
        t_reset;
        t_addr_widths;
        t_continuous;
        t_exit;
        t_enhanced_pattern;
        t_no_quad;
        tally_and_finish;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        tally_and_finish;
    end
endmodule // quad_ddr_flash_read_tb_top
